/* File: bench/btd_monitor.sv */
`default_nettype none
module btd_monitor (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic master_write_request_n,
	input wire logic phys_addr_strobe_n,
	input wire logic local_data_strobe_n,
	input wire logic local_cycle_ack_n,
	input wire logic vme_addr_latch_ctl,
	input wire logic local_addr_latch_pulse_n,
	input wire logic vme_bus_req,
	input wire logic vme_bbsy_n,
	input wire logic vme_as_n,
	input wire logic vme_cycle_go,
	input wire logic local_bus_req_n,
	input wire logic local_bus_grant_n,
	input wire logic local_addr_drive_en,
	input wire logic dma_addr_strobe_n,
	input wire logic iack_request,
	input wire logic deadlock_response,
	input wire logic master_cycle_pass
);
	// ==========
	// dual-path shadow, latch pulse level
	logic dual_r;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dual_r <= 1'b0;
		end else if (reg_wr && reg_addr == btd_pkg::REG_DEF) begin
			dual_r <= reg_wdata[btd_pkg::DEF_DUAL_BIT];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_init_end;
		!local_cycle_ack_n ##1 local_cycle_ack_n;
	endsequence
	sequence s_xing;
		$rose(vme_as_n) && !vme_bbsy_n;
	endsequence
	// ==========
	// properties
	a_init_local_latch: assert property ($fell(local_cycle_ack_n) |-> $fell(local_addr_latch_pulse_n))
		else $error("init local latch");
	a_init_vme_latch: assert property ($fell(local_cycle_ack_n) |-> vme_addr_latch_ctl == dual_r)
		else $error("init vme latch");
	a_ack_holds_ds: assert property (!local_cycle_ack_n && !local_data_strobe_n |=> !local_cycle_ack_n)
		else $error("ack dropped");
	a_req_after_ack: assert property (s_init_end |-> ##[0:1] vme_bus_req)
		else $error("no vme request");
	a_no_req_ack: assert property (!local_cycle_ack_n |-> !vme_bus_req)
		else $error("early vme request");
	a_local_after_vme: assert property ($fell(local_bus_req_n) |-> !vme_bbsy_n)
		else $error("early local request");
	a_strobe_owns_bus: assert property (!dma_addr_strobe_n |-> !local_bus_grant_n && local_addr_drive_en)
		else $error("strobe without bus");
	a_local_latch_short: assert property (!local_addr_latch_pulse_n |=> local_addr_latch_pulse_n)
		else $error("long local latch");
	a_vme_latch_short: assert property ($fell(vme_addr_latch_ctl) && !dual_r |=> vme_addr_latch_ctl)
		else $error("long vme latch");
	a_xing_restrobe: assert property (s_xing |=> !vme_as_n)
		else $error("no restrobe");
	a_go_in_strobe: assert property (vme_cycle_go |-> !vme_as_n)
		else $error("cycle without strobe");
	a_iack_dead: assert property (iack_request && !vme_bbsy_n |-> deadlock_response)
		else $error("iack not deadlocked");
	a_dead_cause: assert property (deadlock_response |-> iack_request
		|| (!master_write_request_n && !phys_addr_strobe_n))
		else $error("stray deadlock");
	a_pass_dual: assert property (master_cycle_pass |-> dual_r && !deadlock_response)
		else $error("pass without dual");
endmodule : btd_monitor
`default_nettype wire

/* File: bench/btd_partner.sv */
`default_nettype none
module btd_partner (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic vme_bus_req,
	input wire logic vme_cycle_go,
	input wire logic local_bus_req_n,
	input wire logic dma_addr_strobe_n,
	output logic vme_bus_grant,
	output logic vme_cycle_done,
	output logic local_bus_grant_n,
	output logic local_ack_n,
	output logic [31:0] vme_rdata,
	output logic [31:0] mem_rdata
);
	logic [1:0] vwait;
	logic [1:0] lwait;
	logic vbusy;
	// ==========
	// arbiters grant one cycle after request
	always_ff @(posedge core_clk) begin
		vme_bus_grant <= reset_n && vme_bus_req;
		local_bus_grant_n <= !reset_n || local_bus_req_n;
	end
	// ==========
	// vme slave; slow stretches cycles
	always_ff @(posedge core_clk) begin
		vme_cycle_done <= 1'b0;
		if (!reset_n) begin
			vbusy <= 1'b0;
		end else if (vme_cycle_go) begin
			vbusy <= 1'b1;
			vwait <= slow ? 2'h3 : 2'h0;
		end else if (vbusy && vwait == 2'h0) begin
			vbusy <= 1'b0;
			vme_cycle_done <= 1'b1;
		end else begin
			vwait <= vwait - 2'h1;
		end
	end
	// ==========
	// local memory; data churns so stale values show
	always_ff @(posedge core_clk) begin
		local_ack_n <= 1'b1;
		mem_rdata <= reset_n ? ~mem_rdata : 32'h5a5a3c3c;
		vme_rdata <= reset_n ? ~vme_rdata : 32'h0ff0c33c;
		if (!reset_n || dma_addr_strobe_n || !local_ack_n) begin
			lwait <= slow ? 2'h2 : 2'h0;
		end else if (lwait == 2'h0) begin
			local_ack_n <= 1'b0;
		end else begin
			lwait <= lwait - 2'h1;
		end
	end
endmodule : btd_partner
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, reset_n, reg_wr, reg_rd, master_write_request_n, phys_addr_strobe_n;
	logic local_data_strobe_n, local_cycle_ack_n, vme_addr_latch_ctl, local_addr_latch_pulse_n;
	logic vme_bus_req, vme_bus_grant, vme_bbsy_n, vme_as_n, vme_cycle_go, vme_cycle_done, vme_d32;
	logic local_bus_req_n, local_bus_grant_n, local_addr_drive_en, dma_addr_strobe_n, local_ack_n;
	logic iack_request, deadlock_response, master_cycle_pass, slow;
	logic [3:0] q;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, local_address_bus, local_data_bus, dma_local_addr;
	logic [6:0] vme_addr_lo;
	logic [31:0] vme_rdata, mem_rdata;
	int comparisons = 0, fail_count = 0, go_cnt = 0, xcnt = 0, lpcnt = 0, vlcnt = 0;
	int brw = 0, vrq = 0, lrl = 0;
	btd_top #(.ILV_UNIT(2)) btd_top_i (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .master_write_request_n, .phys_addr_strobe_n, .local_data_strobe_n,
		.local_address_bus, .local_data_bus, .local_cycle_ack_n, .vme_addr_latch_ctl,
		.local_addr_latch_pulse_n, .vme_bus_req, .vme_bus_grant, .vme_bbsy_n, .vme_as_n,
		.vme_addr_lo, .vme_cycle_go, .vme_cycle_done, .vme_bus_err(1'b0), .vme_d32, .vme_rdata,
		.local_bus_req_n, .local_bus_grant_n, .local_addr_drive_en, .dma_local_addr,
		.dma_addr_strobe_n, .dma_data_strobe_n(), .dma_write(), .local_ack_n,
		.local_bus_err_n(1'b1), .mem_rdata, .xfer_data(), .iack_request, .deadlock_response,
		.master_cycle_pass);
	btd_partner btd_partner_i (.core_clk, .reset_n, .slow, .vme_bus_req, .vme_cycle_go,
		.local_bus_req_n, .dma_addr_strobe_n, .vme_bus_grant, .vme_cycle_done,
		.local_bus_grant_n, .local_ack_n, .vme_rdata, .mem_rdata);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========
	// event counters
	always @(posedge core_clk) begin
		go_cnt += int'(vme_cycle_go);
		lpcnt += int'(!local_addr_latch_pulse_n);
		vlcnt += int'(!vme_addr_latch_ctl);
		xcnt += int'(vme_as_n && !q[3] && !vme_bbsy_n);
		brw += int'(vme_bbsy_n && !q[2] && !vme_as_n);
		vrq += int'(vme_bus_req && !q[1]);
		lrl += int'(local_bus_req_n && !q[0]);
		q = {vme_as_n, vme_bbsy_n, vme_bus_req, local_bus_req_n};
	end
	// ==========
	// shared tasks
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
	task automatic start(input logic [7:0] va, la, input logic dual);
		@(posedge core_clk);
		local_address_bus <= va;
		local_data_bus <= la;
		master_write_request_n <= 1'b0;
		phys_addr_strobe_n <= 1'b0;
		local_data_strobe_n <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk("local latch", 1'b0, local_addr_latch_pulse_n);
		chk("vme latch", dual, vme_addr_latch_ctl);
		chk("ack before req", 2'b00, {local_cycle_ack_n, vme_bus_req});
		@(posedge core_clk);
		master_write_request_n <= 1'b1;
		phys_addr_strobe_n <= 1'b1;
		local_data_strobe_n <= 1'b1;
	endtask : start
	task automatic run(input logic [7:0] ctl, def, rel, lo, va, la, input int ncyc);
		int g0, n;
		logic [7:0] d;
		wr(btd_pkg::REG_DEF, def);
		wr(btd_pkg::REG_REL, rel);
		wr(btd_pkg::REG_LEN_LO, lo);
		wr(btd_pkg::REG_LEN_HI, 8'h00);
		wr(btd_pkg::REG_CTRL, ctl | 8'h40);
		g0 = go_cnt;
		start(va, la, def[0]);
		chk("local address", la, dma_local_addr);
		chk("vme address", va[7:1], vme_addr_lo);
		n = 0;
		do begin rd(btd_pkg::REG_STAT, d); n++; end while (d[0] !== 1'b1 && n < 3000);
		chk("done flag", 1'b1, d[0]);
		chk("vme cycles", ncyc, go_cnt - g0);
		chk("buses freed", 2'b01, {vme_bus_req, local_bus_req_n});
		wr(btd_pkg::REG_CTRL, 8'h00);
		wr(btd_pkg::REG_STAT, 8'h05);
	endtask : run
	// ==========
	// scenarios
	task automatic t_regs;
		logic [7:0] d;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], d);
			chk("reset value", 8'h00, d);
		end
		wr(btd_pkg::REG_REL, 8'h3f);
		rd(btd_pkg::REG_REL, d);
		chk("burst field", 8'h3f, d);
		wr(3'h6, 8'hff);
		rd(3'h6, d);
		chk("unmapped", 8'h00, d);
	endtask : t_regs
	task automatic t_bursts;
		int v0, l0;
		run(8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h40, 4);
		v0 = vrq;
		l0 = lrl;
		run(8'h00, 8'h00, 8'h02, 8'h20, 8'h00, 8'h00, 8);
		chk("vme requests", 4, vrq - v0);
		chk("local releases", 1, lrl - l0);
		run(8'h20, 8'h00, 8'h03, 8'h41, 8'h00, 8'h00, 3);
		vme_d32 <= 1'b0;
		run(8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 4);
		vme_d32 <= 1'b1;
	endtask : t_bursts
	task automatic t_cross;
		int x0, l0, v0, b0;
		for (int rw = 0; rw < 2; rw++) begin
			x0 = xcnt;
			l0 = lpcnt;
			v0 = vlcnt;
			b0 = brw;
			run(8'h00, 8'h0c, rw ? 8'h40 : 8'h00, 8'h10, 8'hf8, 8'hf8, 4);
			chk("strobe toggles", 1, xcnt - x0);
			chk("local latch pulses", 2, lpcnt - l0);
			chk("vme latch pulses", 2, vlcnt - v0);
			chk("busy released early", rw, brw - b0);
		end
	endtask : t_cross
	task automatic t_deadlock;
		int n;
		slow <= 1'b1;
		for (int dp = 0; dp < 2; dp++) begin
			fork
				run(8'h03, dp[7:0], 8'h01, 8'h10, 8'h00, 8'h00, 4);
				begin
					n = 0;
					while (vme_bbsy_n !== 1'b0 && n < 99) begin @(negedge core_clk); n++; end
					@(posedge core_clk);
					iack_request <= 1'b1;
					@(negedge core_clk);
					chk("iack deadlock", 1'b1, deadlock_response);
					@(posedge core_clk);
					iack_request <= 1'b0;
					while (vme_bbsy_n !== 1'b1 && n < 199) begin @(negedge core_clk); n++; end
					@(posedge core_clk);
					master_write_request_n <= 1'b0;
					phys_addr_strobe_n <= 1'b0;
					@(negedge core_clk);
					chk("interleave cycle", dp ? 2'b01 : 2'b10,
						{deadlock_response, master_cycle_pass});
					@(posedge core_clk);
					master_write_request_n <= 1'b1;
					phys_addr_strobe_n <= 1'b1;
				end
			join
		end
		slow <= 1'b0;
	endtask : t_deadlock
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// ==========
	// main sequence and watchdog
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, iack_request, slow} = '0;
		{master_write_request_n, phys_addr_strobe_n, local_data_strobe_n, vme_d32} = 4'hf;
		{local_address_bus, local_data_bus} = 16'h0000;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		t_regs;
		t_bursts;
		t_cross;
		t_deadlock;
		final_report;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		fail_count++;
		final_report;
	end
endmodule : tb
bind btd_top btd_monitor btd_monitor_i (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.master_write_request_n, .phys_addr_strobe_n, .local_data_strobe_n, .local_cycle_ack_n,
	.vme_addr_latch_ctl, .local_addr_latch_pulse_n, .vme_bus_req, .vme_bbsy_n, .vme_as_n,
	.vme_cycle_go, .local_bus_req_n, .local_bus_grant_n, .local_addr_drive_en,
	.dma_addr_strobe_n, .iack_request, .deadlock_response, .master_cycle_pass);
`default_nettype wire

/* File: hw/btd_addr_cnt.sv */
`default_nettype none
module btd_addr_cnt #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic inc,
	input wire logic [W-1:0] step,
	output logic [W-1:0] cnt,
	output logic wrap_next
);
	logic [W-1:0] cnt_r;
	logic [W:0] sum;

	assign sum = {1'b0, cnt_r} + {1'b0, step};
	// carry out marks the cycle before a crossing
	assign wrap_next = sum[W];
	assign cnt = cnt_r;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (inc) begin
			cnt_r <= sum[W-1:0];
		end
	end
endmodule : btd_addr_cnt
`default_nettype wire

/* File: hw/btd_ilv_timer.sv */
`default_nettype none
module btd_ilv_timer #(
	parameter int UNIT = btd_pkg::ILV_UNIT_CYC,
	parameter int W = btd_pkg::CTRL_ILV_W
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [W-1:0] units,
	output logic expired
);
	localparam logic [15:0] PRE_TOP = 16'(UNIT - 1);
	logic [15:0] pre_r;
	logic [W-1:0] left_r;
	logic tick;

	// one-cycle enable per interleave unit
	assign tick = (pre_r == PRE_TOP);
	assign expired = (left_r == '0) && !load;

	always_ff @(posedge core_clk) begin
		if (!reset_n || load || tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			left_r <= '0;
		end else if (load) begin
			left_r <= units;
		end else if (tick && left_r != '0) begin
			left_r <= left_r - 1'b1;
		end
	end
endmodule : btd_ilv_timer
`default_nettype wire

/* File: hw/btd_pkg.sv */
`default_nettype none
package btd_pkg;
	// =====================================================
	// register map
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_DEF = 3'h1;
	localparam logic [2:0] REG_REL = 3'h2;
	localparam logic [2:0] REG_LEN_LO = 3'h3;
	localparam logic [2:0] REG_LEN_HI = 3'h4;
	localparam logic [2:0] REG_STAT = 3'h5;
	// =====================================================
	// field positions
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_RD_BIT = 5;
	localparam int CTRL_ILV_LSB = 0;
	localparam int CTRL_ILV_W = 4;
	localparam int DEF_DUAL_BIT = 0;
	localparam int DEF_LBC_BIT = 2;
	localparam int DEF_VBC_BIT = 3;
	localparam int REL_BURST_LSB = 0;
	localparam int REL_BURST_W = 6;
	localparam int REL_RWD_BIT = 6;
	localparam int LEN_SINGLE_BIT = 0;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_ERR_BIT = 2;
	// =====================================================
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DEF_RST = 8'h00;
	localparam logic [7:0] REL_RST = 8'h00;
	localparam logic [7:0] LEN_RST = 8'h00;
	// =====================================================
	// counts and timing
	localparam logic [6:0] BURST_MAX = 7'h40;
	localparam logic [7:0] BPC_D32 = 8'h04;
	localparam logic [7:0] BPC_D16 = 8'h02;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ILV_UNIT_NS = 1000;
	localparam int ILV_UNIT_CYC = ILV_UNIT_NS / CLK_PERIOD_NS;
	// =====================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_INIT_ACK, ST_VREQ, ST_LREQ, ST_LOC, ST_VME,
		ST_NEXT, ST_XCROSS, ST_ILV, ST_DONE
	} btd_state_t;
endpackage : btd_pkg
`default_nettype wire

/* File: hw/btd_top.sv */
// Overview of operation
// RULE1: enabled master write with strobes starts transfer
// RULE2: initiator starts with write carrying local address
// RULE3: load vme counter, pulse vme latch control
// RULE4: load local counter, pulse local latch
// RULE5: ack init, request vme, then local
// RULE6: external logic drives upper local address
// RULE7: strobed local access, acked, data held
// RULE8: burst of 1-64 cycles, zero means 64
// RULE9: byte length; bit0 set means one burst
// RULE10: vme crossing toggles strobe, keeps busy
// RULE11: release busy after restrobe when release-when-done
// RULE12: external logic increments upper vme address
// RULE13: latch control pulses before vme crossing
// RULE14: local latch pulses before local crossing
// RULE15: interleave period between bursts, slaves served
// RULE16: interleave master requests deadlock unless dual
// RULE17: interrupt acknowledge always deadlocked in transfer
// RULE18: external logic preserves addresses when dual
// RULE19: software clears enable after completion
// RULE20: local side should disable deadlock retry
// RULE21: completion shown in status bit zero
// RULE22: dual path enabled by definition bit zero
// RULE23: zero interleave re-requests vme, keeps local
// RULE24: end on count or error, release, report
`default_nettype none
module btd_top #(
	parameter int DW = 32,
	parameter int ILV_UNIT = btd_pkg::ILV_UNIT_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic master_write_request_n,
	input wire logic phys_addr_strobe_n,
	input wire logic local_data_strobe_n,
	input wire logic [7:0] local_address_bus,
	input wire logic [7:0] local_data_bus,
	output logic local_cycle_ack_n,
	output logic vme_addr_latch_ctl,
	output logic local_addr_latch_pulse_n,
	output logic vme_bus_req,
	input wire logic vme_bus_grant,
	output logic vme_bbsy_n,
	output logic vme_as_n,
	output logic [6:0] vme_addr_lo,
	output logic vme_cycle_go,
	input wire logic vme_cycle_done,
	input wire logic vme_bus_err,
	input wire logic vme_d32,
	input wire logic [DW-1:0] vme_rdata,
	output logic local_bus_req_n,
	input wire logic local_bus_grant_n,
	output logic local_addr_drive_en,
	output logic [7:0] dma_local_addr,
	output logic dma_addr_strobe_n,
	output logic dma_data_strobe_n,
	output logic dma_write,
	input wire logic local_ack_n,
	input wire logic local_bus_err_n,
	input wire logic [DW-1:0] mem_rdata,
	output logic [DW-1:0] xfer_data,
	input wire logic iack_request,
	output logic deadlock_response,
	output logic master_cycle_pass
);
	// =====================================================
	// registers
	logic [7:0] ctrl_r, def_r, rel_r, len_lo_r, len_hi_r;
	logic done_r, err_r;
	logic set_done, set_err;
	logic en, rd_mode, dual, lbc, vbc, release_when_done;

	assign en = ctrl_r[btd_pkg::CTRL_EN_BIT];
	assign rd_mode = ctrl_r[btd_pkg::CTRL_RD_BIT];
	assign dual = def_r[btd_pkg::DEF_DUAL_BIT]; // RULE22
	assign lbc = def_r[btd_pkg::DEF_LBC_BIT];
	assign vbc = def_r[btd_pkg::DEF_VBC_BIT];
	assign release_when_done = rel_r[btd_pkg::REL_RWD_BIT];

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ctrl_r <= btd_pkg::CTRL_RST;
			def_r <= btd_pkg::DEF_RST;
			rel_r <= btd_pkg::REL_RST;
			len_lo_r <= btd_pkg::LEN_RST;
			len_hi_r <= btd_pkg::LEN_RST;
		end else if (reg_wr) begin
			if (reg_addr == btd_pkg::REG_CTRL) begin
				ctrl_r <= reg_wdata;
			end else if (reg_addr == btd_pkg::REG_DEF) begin
				def_r <= reg_wdata;
			end else if (reg_addr == btd_pkg::REG_REL) begin
				rel_r <= reg_wdata;
			end else if (reg_addr == btd_pkg::REG_LEN_LO) begin
				len_lo_r <= reg_wdata;
			end else if (reg_addr == btd_pkg::REG_LEN_HI) begin
				len_hi_r <= reg_wdata;
			end
		end
	end

	// sticky flags: a new event wins over a clear
	logic clr_stat;
	assign clr_stat = reg_wr && reg_addr == btd_pkg::REG_STAT;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			if (set_done) begin
				done_r <= 1'b1; // RULE21
			end else if (clr_stat && reg_wdata[btd_pkg::STAT_DONE_BIT]) begin
				done_r <= 1'b0;
			end
			if (set_err) begin
				err_r <= 1'b1;
			end else if (clr_stat && reg_wdata[btd_pkg::STAT_ERR_BIT]) begin
				err_r <= 1'b0;
			end
		end
	end

	// =====================================================
	// sequencer
	btd_pkg::btd_state_t st_r;
	logic busy;
	logic [7:0] stat_val;

	assign busy = (st_r != btd_pkg::ST_IDLE);

	always_comb begin
		stat_val = 8'h00;
		stat_val[btd_pkg::STAT_DONE_BIT] = done_r;
		stat_val[btd_pkg::STAT_BUSY_BIT] = busy;
		stat_val[btd_pkg::STAT_ERR_BIT] = err_r;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == btd_pkg::REG_CTRL) begin
				reg_rdata <= ctrl_r;
			end else if (reg_addr == btd_pkg::REG_DEF) begin
				reg_rdata <= def_r;
			end else if (reg_addr == btd_pkg::REG_REL) begin
				reg_rdata <= rel_r;
			end else if (reg_addr == btd_pkg::REG_LEN_LO) begin
				reg_rdata <= len_lo_r;
			end else if (reg_addr == btd_pkg::REG_LEN_HI) begin
				reg_rdata <= len_hi_r;
			end else if (reg_addr == btd_pkg::REG_STAT) begin
				reg_rdata <= stat_val;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// =====================================================
	// counters and interleave timer
	logic init_hit, vinc, linc, vwrap, lwrap;
	logic [7:0] vcnt, bpc;
	logic tm_load, tm_exp;

	assign bpc = vme_d32 ? btd_pkg::BPC_D32 : btd_pkg::BPC_D16;
	assign init_hit = (st_r == btd_pkg::ST_IDLE) && en && !master_write_request_n
		&& !phys_addr_strobe_n && !local_data_strobe_n; // RULE1

	btd_addr_cnt #(.W(8)) u_vcnt (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(init_hit),
		.load_val(local_address_bus), // RULE3
		.inc(vinc),
		.step(bpc),
		.cnt(vcnt),
		.wrap_next(vwrap)
	);

	btd_addr_cnt #(.W(8)) u_lcnt (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(init_hit),
		.load_val(local_data_bus), // RULE4
		.inc(linc),
		.step(bpc),
		.cnt(dma_local_addr),
		.wrap_next(lwrap)
	);

	// only seven address lines leave
	assign vme_addr_lo = vcnt[7:1]; // RULE12

	btd_ilv_timer #(.UNIT(ILV_UNIT), .W(btd_pkg::CTRL_ILV_W)) u_ilv (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(tm_load),
		.units(ctrl_r[btd_pkg::CTRL_ILV_LSB +: btd_pkg::CTRL_ILV_W]),
		.expired(tm_exp)
	);

	// =====================================================
	// transfer state
	logic [15:0] left_r;
	logic [6:0] burst_r;
	logic single_r, lheld_r, go_sent_r, xing_r, vpulse_r, lpulse_r;
	logic [DW-1:0] hold_r;
	logic last_cyc, ilv_zero;
	logic [6:0] burst_len;

	assign burst_len = (rel_r[btd_pkg::REL_BURST_LSB +: btd_pkg::REL_BURST_W] == '0)
		? btd_pkg::BURST_MAX
		: {1'b0, rel_r[btd_pkg::REL_BURST_LSB +: btd_pkg::REL_BURST_W]}; // RULE8
	assign ilv_zero = (ctrl_r[btd_pkg::CTRL_ILV_LSB +: btd_pkg::CTRL_ILV_W] == '0);
	assign last_cyc = single_r ? 1'b0 : (left_r == '0);
	assign vinc = (st_r == btd_pkg::ST_VME) && vme_cycle_done;
	assign linc = (st_r == btd_pkg::ST_LOC) && !local_ack_n;
	assign tm_load = (st_r == btd_pkg::ST_NEXT) && (burst_r == '0);
	assign set_err = (vinc && vme_bus_err) || (linc && !local_bus_err_n);
	assign set_done = (st_r == btd_pkg::ST_DONE);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_r <= btd_pkg::ST_IDLE;
		end else begin
			case (st_r)
				btd_pkg::ST_IDLE: begin
					if (init_hit) begin
						st_r <= btd_pkg::ST_INIT_ACK;
					end
				end
				btd_pkg::ST_INIT_ACK: begin
					if (local_data_strobe_n) begin
						st_r <= btd_pkg::ST_VREQ; // RULE5
					end
				end
				btd_pkg::ST_VREQ: begin
					if (vme_bus_grant) begin
						st_r <= lheld_r ? (rd_mode ? btd_pkg::ST_VME : btd_pkg::ST_LOC)
							: btd_pkg::ST_LREQ;
					end
				end
				btd_pkg::ST_LREQ: begin
					if (!local_bus_grant_n) begin
						st_r <= rd_mode ? btd_pkg::ST_VME : btd_pkg::ST_LOC;
					end
				end
				btd_pkg::ST_LOC: begin
					if (!local_ack_n) begin
						if (!local_bus_err_n) begin
							st_r <= btd_pkg::ST_DONE; // RULE24
						end else begin
							st_r <= rd_mode ? btd_pkg::ST_NEXT : btd_pkg::ST_VME;
						end
					end
				end
				btd_pkg::ST_VME: begin
					if (vme_cycle_done) begin
						if (vme_bus_err) begin
							st_r <= btd_pkg::ST_DONE; // RULE24
						end else begin
							st_r <= rd_mode ? btd_pkg::ST_LOC : btd_pkg::ST_NEXT;
						end
					end
				end
				btd_pkg::ST_NEXT: begin
					if (last_cyc || (single_r && burst_r == '0)) begin
						st_r <= btd_pkg::ST_DONE; // RULE9 RULE24
					end else if (burst_r == '0) begin
						st_r <= ilv_zero ? btd_pkg::ST_VREQ : btd_pkg::ST_ILV; // RULE23
					end else if (xing_r) begin
						st_r <= btd_pkg::ST_XCROSS; // RULE10
					end else begin
						st_r <= rd_mode ? btd_pkg::ST_VME : btd_pkg::ST_LOC;
					end
				end
				btd_pkg::ST_XCROSS: begin
					st_r <= rd_mode ? btd_pkg::ST_VME : btd_pkg::ST_LOC;
				end
				btd_pkg::ST_ILV: begin
					if (tm_exp) begin
						st_r <= btd_pkg::ST_VREQ; // RULE15
					end
				end
				btd_pkg::ST_DONE: begin
					st_r <= btd_pkg::ST_IDLE;
				end
				default: begin
					st_r <= btd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// length, burst and crossing bookkeeping
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			left_r <= '0;
			burst_r <= '0;
			single_r <= 1'b0;
			xing_r <= 1'b0;
		end else if (init_hit) begin
			left_r <= {len_hi_r, len_lo_r}; // RULE9
			single_r <= len_lo_r[btd_pkg::LEN_SINGLE_BIT];
			burst_r <= burst_len;
			xing_r <= 1'b0;
		end else if (vinc) begin
			left_r <= (left_r > {8'h00, bpc}) ? left_r - {8'h00, bpc} : '0;
			burst_r <= burst_r - 7'h01;
			xing_r <= vbc && vwrap;
		end else if (st_r == btd_pkg::ST_XCROSS) begin
			xing_r <= 1'b0;
		end else if (st_r == btd_pkg::ST_VREQ && vme_bus_grant) begin
			burst_r <= burst_len;
			xing_r <= 1'b0;
		end
	end

	// data held between bus halves
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			hold_r <= '0;
		end else if (linc && !rd_mode) begin
			hold_r <= mem_rdata; // RULE7
		end else if (vinc && rd_mode) begin
			hold_r <= vme_rdata;
		end
	end
	assign xfer_data = hold_r;

	// =====================================================
	// vme ownership: bbsy held through crossings, released per policy
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			vme_bus_req <= 1'b0;
			vme_bbsy_n <= 1'b1;
			vme_as_n <= 1'b1;
			go_sent_r <= 1'b0;
		end else begin
			vme_bus_req <= (st_r == btd_pkg::ST_INIT_ACK && local_data_strobe_n)
				|| (st_r == btd_pkg::ST_VREQ && !vme_bus_grant)
				|| (st_r == btd_pkg::ST_NEXT && tm_load && ilv_zero && !last_cyc
					&& !single_r);
			if (st_r == btd_pkg::ST_VREQ && vme_bus_grant) begin
				vme_bbsy_n <= 1'b0;
				vme_as_n <= 1'b0;
			end else if (st_r == btd_pkg::ST_NEXT && xing_r && burst_r != '0) begin
				vme_as_n <= 1'b1; // RULE10
			end else if (st_r == btd_pkg::ST_XCROSS) begin
				vme_as_n <= 1'b0;
				if (release_when_done) begin
					vme_bbsy_n <= 1'b1; // RULE11
				end
			end else if (tm_load || st_r == btd_pkg::ST_DONE) begin
				vme_bbsy_n <= 1'b1;
				vme_as_n <= 1'b1;
			end
			if (st_r != btd_pkg::ST_VME) begin
				go_sent_r <= 1'b0;
			end else begin
				go_sent_r <= !vme_cycle_done;
			end
		end
	end
	assign vme_cycle_go = (st_r == btd_pkg::ST_VME) && !go_sent_r;

	// local ownership: kept across a zero interleave
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			lheld_r <= 1'b0;
		end else if (st_r == btd_pkg::ST_LREQ && !local_bus_grant_n) begin
			lheld_r <= 1'b1;
		end else if ((tm_load && !ilv_zero) || st_r == btd_pkg::ST_DONE) begin
			lheld_r <= 1'b0; // RULE23
		end
	end

	assign local_bus_req_n = !(st_r == btd_pkg::ST_LREQ || lheld_r); // RULE5
	assign local_addr_drive_en = lheld_r;
	assign dma_addr_strobe_n = !(st_r == btd_pkg::ST_LOC); // RULE7
	assign dma_data_strobe_n = !(st_r == btd_pkg::ST_LOC);
	assign dma_write = rd_mode;
	assign local_cycle_ack_n = !(st_r == btd_pkg::ST_INIT_ACK); // RULE5

	// =====================================================
	// latch pulses; vme polarity follows dual path
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			vpulse_r <= 1'b0;
			lpulse_r <= 1'b0;
		end else begin
			vpulse_r <= init_hit || (vme_cycle_go && vbc && vwrap); // RULE3 RULE13
			lpulse_r <= init_hit || (st_r == btd_pkg::ST_LOC && local_ack_n
				&& lbc && lwrap && !lpulse_r); // RULE4 RULE14
		end
	end
	assign vme_addr_latch_ctl = vpulse_r ? dual : !dual; // RULE13
	assign local_addr_latch_pulse_n = !lpulse_r;

	// =====================================================
	// requests while a transfer runs
	logic mreq;
	assign mreq = !master_write_request_n && !phys_addr_strobe_n;
	assign master_cycle_pass = (st_r == btd_pkg::ST_ILV) && dual && mreq; // RULE16
	assign deadlock_response = busy && st_r != btd_pkg::ST_INIT_ACK
		&& (iack_request // RULE17
			|| (mreq && !(st_r == btd_pkg::ST_ILV && dual))); // RULE16
endmodule : btd_top
`default_nettype wire
